/* File: panel_operation_and_timer.sv */
/*
 panel_operation_and_timer: key handling, level navigation, timer, value path.
 assumes raw keys and logic input are asynchronous pins; measured value, tolerance
 flag and output states come from logic on mclk; registers over Avalon-MM.
*/
// How it works
// RULE_01 - display value clamped to -1999..9999, decimals and unit from control
// RULE_02 - two leds mirror the two controller output states
// RULE_03 - up/down edit value; taken over after two quiet seconds
// RULE_04 - normal view shows the corrected filtered process value
// RULE_05 - operating level edits setpoint; shows selected setpoint when switching active
// RULE_06 - ramp enabled: operating level shows ramp setpoint
// RULE_07 - timer enabled: operating level shows timer value or start value
// RULE_08 - configuration reached only via the working point parameter
// RULE_09 - timer level edits start value; current value only once started; underscore
// RULE_10 - thirty seconds idle returns to normal view
// RULE_11 - power-on timer mode: time-out returns to operating level
// RULE_12 - no time-out while timer value shown at operating level
// RULE_13 - keys drive timer only while timer shown at operating level
// RULE_14 - logic input in timer mode is a timer key from any view
// RULE_15 - timer states idle, started, running, stopped, run down with key moves
// RULE_16 - started waits for tolerance reached before running
// RULE_17 - up or down key acknowledges run down; start value shown again
// RULE_18 - decimal point blinks while timer started
// RULE_19 - irrelevant parameters are skipped in the parameter walk
// RULE_20 - standard signals scaled linearly onto start and end values
// RULE_21 - signed correction added to the measured value
// RULE_22 - second order low pass, zero time constant bypasses
// RULE_23 - logic input edges step the timer
// RULE_24 - level inhibit blocks parameter and configuration levels
// RULE_25 - any key press restarts acceptance and time-out counters
`timescale 1ns/1ps
module panel_operation_and_timer
  import panel_pkg::*;
#(
  parameter int unsigned ACCEPT_CYC = ACCEPT_MS * MS_CYC,
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_MS * MS_CYC,
  parameter int unsigned BLINK_CYC = BLINK_MS * MS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // front panel pins
  input wire logic key_p,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic logic_in,
  // measurement path
  input wire logic [15:0] raw_value,
  input wire logic raw_valid,
  input wire logic tol_reached,
  input wire logic [1:0] out_state,
  // display
  output logic [15:0] disp_value,
  output logic [1:0] disp_dec,
  output logic disp_fahr,
  output logic disp_dp_blink,
  output logic disp_underscore,
  output logic [2:0] disp_item,
  output logic [1:0] led,
  output logic [15:0] active_setpoint
);
  import panel_pkg::*;

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'(DISP_MAX)) sat16 = DISP_MAX;
    else if (v < 32'(DISP_MIN)) sat16 = DISP_MIN;
    else sat16 = v[15:0];
  endfunction : sat16

  // synchronisers
  logic [3:0] s1_q, s2_q, s3_q;
  always_ff @(posedge mclk) begin
    s1_q <= {logic_in, key_down, key_up, key_p};
    s2_q <= s1_q;
    // tracks through reset so a pin held high gives no false edge
    s3_q <= s2_q;
  end
  wire [3:0] k = s2_q;
  wire [3:0] rise = s2_q & ~s3_q;
  wire any_key = |rise[2:0];
  wire both = k[1] & k[2];
  wire both_new = both & (rise[1] | rise[2]);

  // registers
  logic [31:0] ctrl_q;
  logic [15:0] sp1_q, sp2_q, ramp_q, tstart_q, tval_q, corr_q, scl_q, sch_q, filt_q;
  view_t view_q;
  tstate_t ts_q;
  logic [2:0] pidx_q;
  logic [15:0] edit_q;
  logic editing_q, t_show_start_q;
  logic [31:0] acc_cnt_q, to_cnt_q, blink_cnt_q, ms_cnt_q;
  logic [9:0] sec_cnt_q;
  logic blink_q, rd_pend_q;
  logic signed [31:0] f1_q, f2_q;

  wire [1:0] li_fn = ctrl_q[C_LOGIC +: 2];
  wire spsw = li_fn == LI_SPSW;
  wire sp_sel2 = spsw & k[3];
  wire lvl_inh = (li_fn == LI_LVL) & k[3];
  wire tim_en = ctrl_q[C_TIMER];
  wire ramp_en = ctrl_q[C_RAMP];
  wire li_edge = (li_fn == LI_TIMER) & (s2_q[3] ^ s3_q[3]);

  // operating level item
  shown_t shown;
  always_comb begin
    shown = sp_sel2 | spsw ? S_SELSP : S_SETPOINT; // RULE_05
    if (ramp_en) shown = S_RAMPSP; // RULE_06
    if (tim_en) shown = t_show_start_q ? S_TSTART : S_TIMERVAL; // RULE_07
  end
  wire timer_shown = (view_q == V_OPER) & tim_en;
  wire key_tmr = timer_shown & any_key & ~k[0]; // RULE_13
  wire t_step = key_tmr | li_edge; // RULE_14 RULE_23
  wire t_tick = ts_q == T_RUNNING && ms_cnt_q == MS_CYC - 1 && sec_cnt_q == 10'd999;

  // parameter walk: 0 sp1 1 sp2 2 ramp 3 corr 4 scl 5 sch 6 filt 7 working point
  function automatic logic pvis(input logic [2:0] i, input logic [31:0] c);
    unique case (i)
      3'd1: pvis = c[C_DOUBLE] | (c[C_LOGIC +: 2] == LI_SPSW); // RULE_19
      3'd2: pvis = c[C_RAMP]; // RULE_19
      3'd4, 3'd5: pvis = c[C_STDSIG]; // RULE_19
      default: pvis = 1'b1;
    endcase
  endfunction : pvis
  wire [2:0] pn1 = pidx_q + 3'd1;
  wire [2:0] pn2 = pidx_q + 3'd2;
  wire [2:0] pnext = pvis(pn1, ctrl_q) ? pn1 : (pvis(pn2, ctrl_q) ? pn2 : pidx_q + 3'd3);

  // working point value lives in the controller, not here
  wire edit_allowed = view_q == V_OPER && !timer_shown || view_q == V_PARAM && pidx_q != 3'd7
    || view_q == V_TIMER && (pidx_q[0] == 1'b0 || ts_q != T_IDLE); // RULE_09
  wire [15:0] param_val = pidx_q == 3'd1 ? sp2_q : pidx_q == 3'd2 ? ramp_q
    : pidx_q == 3'd3 ? corr_q : pidx_q == 3'd4 ? scl_q : pidx_q == 3'd5 ? sch_q
    : pidx_q == 3'd6 ? filt_q : sp1_q;
  wire [15:0] edit_src = view_q == V_TIMER ? (pidx_q[0] ? tval_q : tstart_q)
    : view_q == V_PARAM ? param_val
    : (sp_sel2 ? sp2_q : sp1_q);
  wire commit = editing_q && acc_cnt_q == ACCEPT_CYC - 1; // RULE_03

  // navigation and timer
  always_ff @(posedge mclk) begin
    if (srst) begin
      view_q <= V_NORMAL;
      pidx_q <= 3'd0;
      to_cnt_q <= '0;
      acc_cnt_q <= '0;
      editing_q <= 1'b0;
      edit_q <= 16'h0000;
    end else begin
      if (any_key) begin
        to_cnt_q <= '0; // RULE_25
        acc_cnt_q <= '0; // RULE_25
      end else begin
        if (!timer_shown) to_cnt_q <= to_cnt_q + 32'd1; // RULE_12
        if (editing_q) acc_cnt_q <= acc_cnt_q + 32'd1;
      end
      if (commit) editing_q <= 1'b0;
      if ((rise[1] ^ rise[2]) && !both && edit_allowed) begin
        edit_q <= (editing_q ? edit_q : edit_src) + (rise[1] ? 16'h0001 : 16'hFFFF); // RULE_03
        editing_q <= 1'b1;
      end
      if (!any_key && to_cnt_q == TIMEOUT_CYC - 1) begin
        view_q <= (tim_en && ctrl_q[C_TPWR]) ? V_OPER : V_NORMAL; // RULE_10 RULE_11
        editing_q <= 1'b0;
      end else if (rise[0]) begin
        editing_q <= 1'b0;
        unique case (view_q)
          V_NORMAL: view_q <= k[2] ? V_TIMER : V_OPER;
          V_OPER: begin
            view_q <= lvl_inh ? V_NORMAL : V_PARAM; // RULE_24
            pidx_q <= 3'd0;
          end
          V_PARAM: if (pidx_q == 3'd7) view_q <= V_WORKPT;
            else pidx_q <= pnext;
          V_WORKPT: view_q <= (k[1] && !lvl_inh) ? V_CONFIG : V_NORMAL; // RULE_08 RULE_24
          V_CONFIG: view_q <= V_NORMAL;
          V_TIMER: if (pidx_q[0]) view_q <= V_NORMAL;
            else pidx_q <= 3'd1;
        endcase
      end
    end
  end

  // timer state machine
  always_ff @(posedge mclk) begin
    if (srst) begin
      ts_q <= T_IDLE;
      t_show_start_q <= 1'b1;
      ms_cnt_q <= '0;
      sec_cnt_q <= '0;
    end else begin
      if (ts_q == T_RUNNING) begin
        ms_cnt_q <= (ms_cnt_q == MS_CYC - 1) ? '0 : ms_cnt_q + 32'd1;
        if (ms_cnt_q == MS_CYC - 1) sec_cnt_q <= (sec_cnt_q == 10'd999) ? '0 : sec_cnt_q + 10'd1;
      end
      unique case (ts_q)
        T_IDLE: if (t_step) begin
          ts_q <= T_STARTED; // RULE_15
          t_show_start_q <= 1'b0;
        end
        T_STARTED: if (both_new && timer_shown) ts_q <= T_IDLE; // RULE_15
          else if (tol_reached) ts_q <= T_RUNNING; // RULE_16
        T_RUNNING: if (both_new && timer_shown) ts_q <= T_IDLE;
          else if ((rise[1] && timer_shown && !k[2]) || li_edge) ts_q <= T_STOPPED; // RULE_15
          else if (t_tick && tval_q <= 16'h0001) ts_q <= T_DONE;
        T_STOPPED: if (both_new && timer_shown) ts_q <= T_IDLE;
          else if ((rise[1] && timer_shown && !k[2]) || li_edge) ts_q <= T_RUNNING; // RULE_15
        T_DONE: if (t_step) begin
          ts_q <= T_IDLE; // RULE_17
          t_show_start_q <= 1'b1; // RULE_17
        end
      endcase
      if (both_new && timer_shown && ts_q != T_IDLE && ts_q != T_DONE) t_show_start_q <= 1'b1;
    end
  end

  // blink divider
  always_ff @(posedge mclk) begin
    if (srst) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_CYC - 1) begin
      blink_cnt_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'd1;
    end
  end

  // value path
  wire signed [31:0] span_in = 32'(signed'(sch_q)) - 32'(signed'(scl_q));
  // raw span is unsigned; kept signed so a falling range scales correctly
  wire signed [31:0] raw_span = 32'(signed'({1'b0, raw_value}));
  wire signed [31:0] scaled = 32'(signed'(scl_q)) + (span_in * raw_span) / 32'sd65535;
  wire signed [31:0] meas = ctrl_q[C_STDSIG] ? scaled : 32'(signed'(raw_value)); // RULE_20
  wire signed [31:0] corrected = meas + 32'(signed'(corr_q)); // RULE_21
  wire [5:0] fshift = filt_q == 16'h0 ? 6'd0
    : (filt_q < 16'd8 ? 6'd2 : (filt_q < 16'd64 ? 6'd4 : 6'd6));
  wire signed [31:0] pv_full = filt_q == 16'h0 ? corrected : f2_q; // RULE_22
  wire signed [15:0] pv = sat16(pv_full); // RULE_01
  always_ff @(posedge mclk) begin
    if (srst) begin
      f1_q <= '0;
      f2_q <= '0;
    end else if (raw_valid) begin
      f1_q <= f1_q + ((corrected - f1_q) >>> fshift); // RULE_22
      f2_q <= f2_q + ((f1_q - f2_q) >>> fshift); // RULE_22
    end
  end

  // register writes and edit commits
  wire wr = avs_write;
  wire [7:0] a = avs_address;
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      {sp1_q, sp2_q, ramp_q, corr_q, scl_q} <= {5{SP_RST}};
      tstart_q <= TSTART_RST;
      tval_q <= TSTART_RST;
      sch_q <= SCH_RST;
      filt_q <= FILT_RST;
    end else begin
      if (wr && a == OFS_CTRL) ctrl_q <= avs_writedata;
      if (wr && a == OFS_SP1) sp1_q <= avs_writedata[15:0];
      if (wr && a == OFS_SP2) sp2_q <= avs_writedata[15:0];
      if (wr && a == OFS_RAMP) ramp_q <= avs_writedata[15:0];
      if (wr && a == OFS_TSTART) tstart_q <= avs_writedata[15:0];
      if (wr && a == OFS_CORR) corr_q <= avs_writedata[15:0];
      if (wr && a == OFS_SCL) scl_q <= avs_writedata[15:0];
      if (wr && a == OFS_SCH) sch_q <= avs_writedata[15:0];
      if (wr && a == OFS_FILT) filt_q <= avs_writedata[15:0];
      if (ts_q == T_IDLE) tval_q <= tstart_q;
      else if (t_tick && tval_q != 16'h0) tval_q <= tval_q - 16'h0001;
      if (commit && view_q == V_TIMER) begin
        if (pidx_q[0]) tval_q <= edit_q; // RULE_09
        else tstart_q <= edit_q; // RULE_09
      end else if (commit && view_q == V_PARAM) begin
        unique case (pidx_q)
          3'd1: sp2_q <= edit_q;
          3'd2: ramp_q <= edit_q;
          3'd3: corr_q <= edit_q;
          3'd4: scl_q <= edit_q;
          3'd5: sch_q <= edit_q;
          3'd6: filt_q <= edit_q;
          default: sp1_q <= edit_q;
        endcase
      end else if (commit) begin
        if (sp_sel2) sp2_q <= edit_q; // RULE_05
        else sp1_q <= edit_q; // RULE_05
      end
    end
  end

  // read side: one wait state
  wire [31:0] status = {20'h0, 1'b0, ts_q, 1'b0, view_q, editing_q, lvl_inh, sp_sel2, timer_shown};
  wire [31:0] rmux = a == OFS_CTRL ? ctrl_q : a == OFS_STATUS ? status
    : a == OFS_SP1 ? {16'h0, sp1_q} : a == OFS_SP2 ? {16'h0, sp2_q}
    : a == OFS_RAMP ? {16'h0, ramp_q} : a == OFS_TSTART ? {16'h0, tstart_q}
    : a == OFS_TVAL ? {16'h0, tval_q} : a == OFS_CORR ? {16'h0, corr_q}
    : a == OFS_SCL ? {16'h0, scl_q} : a == OFS_SCH ? {16'h0, sch_q}
    : a == OFS_FILT ? {16'h0, filt_q} : a == OFS_PV ? {16'h0, pv}
    : a == OFS_DISP ? {16'h0, disp_value} : UNMAPPED_RD;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_pend_q <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rd_pend_q <= avs_read & ~rd_pend_q;
      if (avs_read && !rd_pend_q) avs_readdata <= rmux;
    end
  end
  assign avs_waitrequest = avs_read & ~rd_pend_q;

  // display
  wire [15:0] oper_val = shown == S_TIMERVAL ? tval_q : shown == S_TSTART ? tstart_q
    : shown == S_RAMPSP ? ramp_q : (sp_sel2 ? sp2_q : sp1_q);
  wire [15:0] view_val = editing_q ? edit_q : view_q == V_NORMAL ? pv // RULE_04
    : view_q == V_OPER ? oper_val
    : view_q == V_TIMER ? (pidx_q[0] ? tval_q : tstart_q) : edit_src;
  wire show_tval = (view_q == V_OPER && shown == S_TIMERVAL) || (view_q == V_TIMER && pidx_q[0]);
  always_ff @(posedge mclk) begin
    if (srst) begin
      disp_value <= 16'h0000;
      disp_dec <= 2'h0;
      disp_fahr <= 1'b0;
      disp_dp_blink <= 1'b0;
      disp_underscore <= 1'b0;
      disp_item <= 3'h0;
      led <= 2'h0;
      active_setpoint <= SP_RST;
    end else begin
      disp_value <= sat16(32'(signed'(view_val))); // RULE_01
      disp_dec <= (ctrl_q[C_DEC +: 2] == 2'h3) ? 2'h2 : ctrl_q[C_DEC +: 2]; // RULE_01
      disp_fahr <= ctrl_q[C_FAHR] & (view_q == V_NORMAL); // RULE_01
      disp_dp_blink <= show_tval && ts_q != T_IDLE && blink_q; // RULE_18
      disp_underscore <= view_q == V_TIMER; // RULE_09
      disp_item <= view_q == V_OPER ? 3'(shown) : pidx_q;
      led <= out_state; // RULE_02
      active_setpoint <= ramp_en ? ramp_q : (sp_sel2 ? sp2_q : sp1_q);
    end
  end
endmodule : panel_operation_and_timer

/* File: panel_pkg.sv */
/*
 panel_pkg: constants, register map and types for the operator panel block.
 assumes a 100 MHz mclk and an Avalon-MM slave with 32-bit data and byte addresses.
*/
package panel_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned ACCEPT_MS = 2000;
  localparam int unsigned TIMEOUT_MS = 30000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned BLINK_MS = 500;
  localparam int unsigned TICK_CYC = 100;
  // byte addresses, one aligned word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SP1 = 8'h08;
  localparam logic [7:0] OFS_SP2 = 8'h0C;
  localparam logic [7:0] OFS_RAMP = 8'h10;
  localparam logic [7:0] OFS_TSTART = 8'h14;
  localparam logic [7:0] OFS_TVAL = 8'h18;
  localparam logic [7:0] OFS_CORR = 8'h1C;
  localparam logic [7:0] OFS_SCL = 8'h20;
  localparam logic [7:0] OFS_SCH = 8'h24;
  localparam logic [7:0] OFS_FILT = 8'h28;
  localparam logic [7:0] OFS_PV = 8'h2C;
  localparam logic [7:0] OFS_DISP = 8'h30;
  // ctrl fields
  localparam int unsigned C_DEC = 0;
  localparam int unsigned C_FAHR = 2;
  localparam int unsigned C_DOUBLE = 3;
  localparam int unsigned C_STDSIG = 4;
  localparam int unsigned C_RAMP = 5;
  localparam int unsigned C_TIMER = 6;
  localparam int unsigned C_TPWR = 7;
  localparam int unsigned C_LOGIC = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] TSTART_RST = 16'h0064;
  localparam logic [15:0] SCH_RST = 16'h03E8;
  localparam logic [15:0] FILT_RST = 16'h0006;
  localparam logic signed [15:0] DISP_MIN = -16'sd1999;
  localparam logic signed [15:0] DISP_MAX = 16'sd9999;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // logic input function codes
  localparam logic [1:0] LI_NONE = 2'h0;
  localparam logic [1:0] LI_SPSW = 2'h1;
  localparam logic [1:0] LI_LVL = 2'h2;
  localparam logic [1:0] LI_TIMER = 2'h3;
  typedef enum logic [2:0] {
    V_NORMAL, V_OPER, V_PARAM, V_WORKPT, V_CONFIG, V_TIMER
  } view_t;
  typedef enum logic [2:0] {
    T_IDLE, T_STARTED, T_RUNNING, T_STOPPED, T_DONE
  } tstate_t;
  typedef enum logic [2:0] {
    S_SETPOINT, S_SELSP, S_RAMPSP, S_TIMERVAL, S_TSTART
  } shown_t;
endpackage : panel_pkg

/* File: panel_props.sv */
/*
 panel_props: concurrent checks on the ports of panel_operation_and_timer.
 assumes it is bound to that module and sees only its ports.
*/
`timescale 1ns/1ps
module panel_props
  import panel_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // outputs and display
  input wire logic [1:0] out_state,
  input wire logic [15:0] disp_value,
  input wire logic [1:0] disp_dec,
  input wire logic [1:0] led,
  input wire logic [15:0] active_setpoint
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence read_ans_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence rst_twice_s;
    srst ##1 srst;
  endsequence
  led_follow_a: assert property (!$past(srst) |-> led == $past(out_state))
    else $error("led does not follow output state");
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  read_wait_a: assert property ($rose(avs_read) |-> read_ans_s)
    else $error("read not answered after one wait cycle");
  idle_nowait_a: assert property (!avs_read |-> !avs_waitrequest)
    else $error("waitrequest without read");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  disp_range_a: assert property ($signed(disp_value) >= DISP_MIN
    && $signed(disp_value) <= DISP_MAX)
    else $error("display value out of range");
  dec_range_a: assert property (disp_dec != 2'h3)
    else $error("more than two decimal places");
  reset_clear_a: assert property (disable iff (1'b0) rst_twice_s |-> led == 2'h0
    && disp_value == 16'h0000 && active_setpoint == 16'h0000 && avs_readdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : panel_props

bind panel_operation_and_timer panel_props panel_props_i (.mclk(mclk), .srst(srst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .out_state(out_state), .disp_value(disp_value),
  .disp_dec(disp_dec), .led(led), .active_setpoint(active_setpoint));

/* File: operator_model.sv */
/*
 operator_model: the operator pressing the three front keys.
 assumes keys are active high and synchronised inside the panel.
*/
`timescale 1ns/1ps
module operator_model (
  // clock
  input wire logic mclk,
  // keys
  output logic key_p,
  output logic key_up,
  output logic key_down
);
  initial begin
    {key_p, key_up, key_down} = 3'h0;
  end
  // chord is {p, up, down}; settle time covers the synchronisers
  task automatic press(input logic [2:0] chord, input int hold);
    @(posedge mclk);
    {key_p, key_up, key_down} <= chord;
    repeat (hold) @(posedge mclk);
    {key_p, key_up, key_down} <= 3'h0;
    repeat (8) @(posedge mclk);
  endtask : press
endmodule : operator_model

/* File: panel_operation_and_timer_tb.sv */
/*
 panel_operation_and_timer_tb: directed tests of registers, value path, levels, timer.
 assumes the panel package, the operator model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module panel_operation_and_timer_tb;
  import panel_pkg::*;
  localparam int unsigned ACC = 50;
  localparam int unsigned TMO = 200;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic key_p, key_up, key_down;
  logic logic_in = 1'b0;
  logic [15:0] raw_value = 16'h0000;
  logic raw_valid = 1'b0;
  logic tol_reached = 1'b0;
  logic [1:0] out_state = 2'h0;
  logic [15:0] disp_value, active_setpoint;
  logic [1:0] disp_dec, led;
  logic [2:0] disp_item;
  logic disp_fahr, disp_dp_blink, disp_underscore;
  logic [31:0] d;
  int n_mismatch = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  operator_model operator_model_i (.mclk(mclk), .key_p(key_p), .key_up(key_up),
    .key_down(key_down));
  panel_operation_and_timer #(.ACCEPT_CYC(ACC), .TIMEOUT_CYC(TMO), .BLINK_CYC(8))
    panel_operation_and_timer_i (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .key_p(key_p),
    .key_up(key_up), .key_down(key_down), .logic_in(logic_in), .raw_value(raw_value),
    .raw_valid(raw_valid), .tol_reached(tol_reached), .out_state(out_state),
    .disp_value(disp_value), .disp_dec(disp_dec), .disp_fahr(disp_fahr),
    .disp_dp_blink(disp_dp_blink), .disp_underscore(disp_underscore),
    .disp_item(disp_item), .led(led), .active_setpoint(active_setpoint));
  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : check
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
  task automatic do_reset();
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
  endtask : do_reset
  task automatic sample(input logic [15:0] v);
    repeat (4) begin
      @(posedge mclk);
      raw_value <= v;
      raw_valid <= 1'b1;
      @(posedge mclk);
      raw_valid <= 1'b0;
    end
    repeat (10) @(posedge mclk);
  endtask : sample
  task automatic view_is(input view_t v);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    check("view", {29'h0, v}, {29'h0, d[6:4]});
  endtask : view_is
  task automatic tstate_is(input tstate_t s);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    check("timer state", {29'h0, s}, {29'h0, d[10:8]});
  endtask : tstate_is
  task automatic flip_logic();
    @(posedge mclk);
    logic_in <= !logic_in;
    repeat (8) @(posedge mclk);
  endtask : flip_logic
  task automatic t_regs();
    xfer(OFS_CTRL, 1'b0, 32'h0);
    check("ctrl reset", CTRL_RST, d);
    xfer(OFS_TSTART, 1'b0, 32'h0);
    check("tstart reset", {16'h0, TSTART_RST}, d);
    xfer(OFS_SCH, 1'b0, 32'h0);
    check("sch reset", {16'h0, SCH_RST}, d);
    xfer(OFS_FILT, 1'b0, 32'h0);
    check("filter reset", {16'h0, FILT_RST}, d);
    xfer(8'h3C, 1'b1, 32'h1234);
    xfer(8'h3C, 1'b0, 32'h0);
    check("unmapped", UNMAPPED_RD, d);
    @(posedge mclk);
    out_state <= 2'h2;
    repeat (3) @(posedge mclk);
    check("led", 32'h2, {30'h0, led});
  endtask : t_regs
  task automatic t_value();
    xfer(OFS_FILT, 1'b1, 32'h0);
    xfer(OFS_CORR, 1'b1, 32'h3);
    sample(16'd100);
    xfer(OFS_PV, 1'b0, 32'h0);
    check("pv plus", 32'd103, d);
    xfer(OFS_CORR, 1'b1, 32'h0000FFFD);
    sample(16'd100);
    xfer(OFS_PV, 1'b0, 32'h0);
    check("pv minus", 32'd97, d);
    xfer(OFS_CTRL, 1'b1, 32'h6);
    xfer(OFS_CORR, 1'b1, 32'd100);
    sample(16'd9990);
    check("disp max", 32'd9999, {16'h0, disp_value});
    check("decimals", 32'h2, {30'h0, disp_dec});
    check("unit", 32'h1, {31'h0, disp_fahr});
    xfer(OFS_CORR, 1'b1, 32'h0);
    sample(16'hF7CC);
    check("disp min", 32'h0000F831, {16'h0, disp_value});
    xfer(OFS_CTRL, 1'b1, 32'h10);
    xfer(OFS_SCL, 1'b1, 32'd20);
    xfer(OFS_SCH, 1'b1, 32'd200);
    sample(16'h0000);
    xfer(OFS_PV, 1'b0, 32'h0);
    check("scaled start", 32'd20, d);
    sample(16'hFFFF);
    xfer(OFS_PV, 1'b0, 32'h0);
    check("scaled end", 32'd200, d);
  endtask : t_value
  task automatic t_levels();
    do_reset();
    operator_model_i.press(3'b100, 4);
    view_is(V_OPER);
    repeat (TMO - 60) @(posedge mclk);
    operator_model_i.press(3'b010, 4);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    check("editing", 32'h1, {31'h0, d[3]});
    repeat (100) @(posedge mclk);
    view_is(V_OPER);
    xfer(OFS_SP1, 1'b0, 32'h0);
    check("accepted sp", 32'h1, d);
    check("active sp", 32'h1, {16'h0, active_setpoint});
    xfer(OFS_SP2, 1'b1, 32'h5);
    xfer(OFS_CTRL, 1'b1, 32'h100);
    @(posedge mclk);
    logic_in <= 1'b1;
    repeat (5) @(posedge mclk);
    check("second sp", 32'h5, {16'h0, active_setpoint});
    repeat (TMO) @(posedge mclk);
    view_is(V_NORMAL);
    xfer(OFS_CTRL, 1'b1, 32'h200);
    @(posedge mclk);
    logic_in <= 1'b1;
    operator_model_i.press(3'b100, 4);
    operator_model_i.press(3'b100, 4);
    view_is(V_NORMAL);
    @(posedge mclk);
    logic_in <= 1'b0;
    operator_model_i.press(3'b100, 4);
    operator_model_i.press(3'b100, 4);
    view_is(V_PARAM);
    operator_model_i.press(3'b100, 4);
    check("param skip", 32'h3, {29'h0, disp_item});
    operator_model_i.press(3'b100, 4);
    check("scale skip", 32'h6, {29'h0, disp_item});
    operator_model_i.press(3'b100, 4);
    operator_model_i.press(3'b100, 4);
    operator_model_i.press(3'b110, 4);
    view_is(V_CONFIG);
  endtask : t_levels
  task automatic t_timer();
    logic b;
    do_reset();
    xfer(OFS_CTRL, 1'b1, 32'h340);
    operator_model_i.press(3'b010, 4);
    tstate_is(T_IDLE);
    flip_logic();
    tstate_is(T_STARTED);
    repeat (30) @(posedge mclk);
    tstate_is(T_STARTED);
    tol_reached <= 1'b1;
    repeat (8) @(posedge mclk);
    tstate_is(T_RUNNING);
    flip_logic();
    tstate_is(T_STOPPED);
    flip_logic();
    tstate_is(T_RUNNING);
    operator_model_i.press(3'b101, 4);
    check("underscore", 32'h1, {31'h0, disp_underscore});
    operator_model_i.press(3'b100, 4);
    operator_model_i.press(3'b100, 4);
    operator_model_i.press(3'b100, 4);
    view_is(V_OPER);
    check("oper item", {29'h0, S_TIMERVAL}, {29'h0, disp_item});
    b = disp_dp_blink;
    repeat (8) @(posedge mclk);
    check("blink", {31'h0, !b}, {31'h0, disp_dp_blink});
    operator_model_i.press(3'b010, 4);
    tstate_is(T_STOPPED);
    operator_model_i.press(3'b011, 4);
    tstate_is(T_IDLE);
    check("start item", {29'h0, S_TSTART}, {29'h0, disp_item});
    repeat (TMO) @(posedge mclk);
    view_is(V_OPER);
    tol_reached <= 1'b0;
    operator_model_i.press(3'b001, 4);
    tstate_is(T_STARTED);
  endtask : t_timer
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
  initial begin
    do_reset();
    t_regs();
    t_value();
    t_levels();
    t_timer();
    test_done();
  end
endmodule : panel_operation_and_timer_tb
